//--- bench/master_station_model.sv
// master station model: framed serial sender and reply collector with stalls
`timescale 1ns/1ps
module master_station_model
  import rsm_pkg::*;
#(
  parameter logic [7:0] SYNC_CHAR = SYNC_DEFAULT
) (
  input  wire logic                core_clk_in,
  output logic                     rx_bit_out,
  output logic                     rx_valid_out,
  input  wire logic                reply_valid_in,
  output logic                     reply_ready_out,
  input  wire logic [MSG_BITS-1:0] reply_data_in
);
  logic [MSG_BITS-1:0] got [$];
  int                  stall;

  initial begin
    rx_bit_out      = 1'b0;
    rx_valid_out    = 1'b0;
    reply_ready_out = 1'b0;
    stall           = 0;
  end

  // the bench loads stall to hold ready low for one cycle fewer than that many
  always @(negedge core_clk_in) begin
    if (stall > 0) begin
      stall--;
    end
    reply_ready_out <= (stall == 0);
  end

  always @(posedge core_clk_in) begin
    if (reply_valid_in === 1'b1 && reply_ready_out === 1'b1) begin
      got.push_back(reply_data_in);
    end
  end

  // two sync characters high bit first, then the 32 message bits, bit 0 first
  task automatic send_msg(input logic [MSG_BITS-1:0] msg, input bit slow);
    for (int i = 0; i < 48; i++) begin
      @(negedge core_clk_in);
      rx_bit_out   <= (i < 16) ? SYNC_CHAR[7 - (i % 8)] : msg[i - 16];
      rx_valid_out <= 1'b1;
      if (slow) begin
        @(negedge core_clk_in);
        rx_valid_out <= 1'b0;
        rx_bit_out   <= ~rx_bit_out;
      end
    end
    @(negedge core_clk_in);
    rx_valid_out <= 1'b0;
    // line idles at the inverse so a stale bit is never mistaken for data
    rx_bit_out   <= ~rx_bit_out;
  endtask
endmodule

//--- bench/remote_station_message_handler_tb_top.sv
// self-checking bench for the remote station message handler
`timescale 1ns/1ps
module remote_station_message_handler_tb_top;
  import rsm_pkg::*;
  localparam int         NP   = 8;
  localparam logic [2:0] STN  = 3'h1;
  // an asymmetric sync pattern exposes any bit-order slip in the framing
  localparam logic [7:0] SYNC = SYNC_DEFAULT;
  logic                core_clk_in;
  logic                rstn_in;
  logic                rx_bit;
  logic                rx_valid;
  logic                reply_valid;
  logic                reply_ready;
  logic [31:0]         reply_data;
  logic                select;
  logic [2:0]          select_code;
  logic                execute;
  logic                a_frz;
  logic                c_frz;
  logic                chk_err;
  logic [NP*12-1:0]    analog_values;
  logic [NP*12-1:0]    counter_values;
  logic [NP-1:0]       over;
  logic [11:0]         an_live [NP];
  logic [11:0]         pc_live [NP];
  logic [11:0]         an_frz [NP];
  logic [11:0]         pc_frz [NP];
  bit                  fa;
  bit                  fc;
  int                  seed = 39872;
  int                  mismatches = 0;
  int                  n_tests = 0;
  int                  exec_cnt = 0;
  int                  err_cnt = 0;

  remote_station_message_handler #(.POINTS(NP), .SYNC_CHAR(SYNC), .STATION(STN)) dut_u (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .rx_bit_in(rx_bit),
    .rx_bit_valid_in(rx_valid), .analog_values_in(analog_values),
    .analog_over_range_in(over), .counter_values_in(counter_values),
    .reply_valid_out(reply_valid), .reply_ready_in(reply_ready),
    .reply_data_out(reply_data), .select_out(select), .select_code_out(select_code),
    .execute_out(execute), .analog_frozen_out(a_frz), .counter_frozen_out(c_frz),
    .check_error_out(chk_err));

  master_station_model #(.SYNC_CHAR(SYNC)) ms_u (
    .core_clk_in(core_clk_in), .rx_bit_out(rx_bit), .rx_valid_out(rx_valid),
    .reply_valid_in(reply_valid), .reply_ready_out(reply_ready),
    .reply_data_in(reply_data));

  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  always_comb begin
    for (int g = 0; g < NP; g++) begin
      analog_values[g*12 +: 12]  = an_live[g];
      counter_values[g*12 +: 12] = pc_live[g];
    end
  end

  always @(posedge core_clk_in) begin
    if (execute === 1'b1) exec_cnt++;
    if (chk_err === 1'b1) err_cnt++;
  end

  function automatic logic [31:0] seal(input logic [23:0] inf);
    logic [7:0]  r;
    logic [31:0] m;
    r = 8'h00;
    for (int i = 0; i < INFO_BITS; i++) r = {r[6:0], 1'b0} ^ ((inf[i] ^ r[7]) ? CHK_POLY : 8'h00);
    m = {8'h00, inf};
    // remainder sent high bit first so the receiver's remainder comes out zero
    for (int k = 0; k < 8; k++) m[24 + k] = r[7 - k];
    return m;
  endfunction

  function automatic logic [31:0] mk(input logic [2:0] ad, cl, cd, input logic [11:0] dt);
    return seal({dt, cd, cl, 3'h0, ad});
  endfunction

  function automatic logic [11:0] exp_an(input int p);
    return fa ? an_frz[p] : (over[p] ? OVER_RANGE : an_live[p]);
  endfunction

  function automatic logic [11:0] exp_pc(input int p);
    return fc ? pc_frz[p] : pc_live[p];
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic new_live(input bit with_over);
    @(negedge core_clk_in);
    for (int g = 0; g < NP; g++) begin
      an_live[g] = 12'($random(seed));
      pc_live[g] = 12'($random(seed));
    end
    over = with_over ? NP'($random(seed)) : '0;
  endtask

  task automatic send(input logic [31:0] m, input bit slow);
    ms_u.send_msg(m, slow);
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask

  task automatic wait_replies(input int n);
    int t;
    t = 0;
    while (ms_u.got.size() < n && t < 300) begin
      @(posedge core_clk_in);
      t++;
    end
    repeat (12) @(posedge core_clk_in);
    check("reply count", n, ms_u.got.size());
  endtask

  task automatic do_read(input int p, input int n, input bit slow);
    logic [31:0] w;
    send(mk(STN, CLS_READ, 3'(n - 1), 12'(p)), slow);
    wait_replies(n);
    for (int k = 0; k < n; k++) begin
      w = ms_u.got.pop_front();
      check("reply check bits", seal(w[23:0]), w);
      check("analog word", exp_an(p + 2*k), w[11:0]);
      check("counter word", exp_pc(p + 2*k + 1), w[23:12]);
    end
  endtask

  task automatic flush;
    repeat (12) @(posedge core_clk_in);
    ms_u.got.delete();
  endtask

  initial begin
    #(25ns * 60000);
    mismatches++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    int p, n, e0;
    logic [2:0] cd, cl;
    logic [31:0] m, pat;
    rstn_in = 1'b0;
    fa = 1'b0;
    fc = 1'b0;
    over = '0;
    for (int g = 0; g < NP; g++) begin
      an_live[g] = 12'h000;
      pc_live[g] = 12'h000;
    end
    repeat (2) @(negedge core_clk_in);
    check("quiet in reset", 6'h00, {reply_valid, select, execute, a_frz, c_frz, chk_err});
    rstn_in = 1'b1;
    for (int i = 0; i < 12; i++) begin
      p = 2 * ($unsigned($random(seed)) % 4);
      n = 1 + $unsigned($random(seed)) % ((NP - p) / 2);
      if (i == 0) begin
        p = 0;
        n = 4;
      end
      new_live(1'b1);
      // long enough to outlast the request, so replies meet a stalled receiver
      ms_u.stall = (i % 3 == 0) ? 120 : 0;
      do_read(p, n, i[0]);
    end
    $display("test reads done");
    for (int i = 0; i < 6; i++) begin
      cd = 3'(1 + i % 3);
      cl = (i < 3) ? CLS_MEM_ACT : CLS_LATCH_ACT;
      m = mk(STN, CLS_CTRL_SEL, cd, 12'h000);
      send(m, i[0]);
      check("selected", 1'b1, select);
      check("selected code", cd, select_code);
      wait_replies(1);
      check("checkback", m, ms_u.got.pop_front());
      e0 = exec_cnt;
      send(mk(STN, cl, (i == 5) ? 3'(cd + 3'h1) : cd, 12'h000), 1'b0);
      check("activate", (i == 5) ? e0 : e0 + 1, exec_cnt);
      wait_replies((i == 5) ? 0 : 1);
      if (i != 5) check("verification", mk(STN, cl, cd, 12'h000), ms_u.got.pop_front());
    end
    send(mk(STN, CLS_CTRL_SEL, 3'h3, 12'h000), 1'b0);
    flush();
    do_read(0, 1, 1'b0);
    check("selection dropped", 1'b0, select);
    e0 = exec_cnt;
    send(mk(STN, CLS_MEM_ACT, 3'h3, 12'h000), 1'b0);
    check("late activate", e0, exec_cnt);
    wait_replies(0);
    $display("test control done");
    for (int i = 0; i < 8; i++) begin
      pat = (i % 4 == 0) ? 32'h1 : (i % 4 == 1) ? 32'h00100001 : (i % 4 == 2) ? 32'hFF : 32'h81;
      pat = pat << ($unsigned($random(seed)) % 12);
      e0 = err_cnt;
      send(mk(STN, CLS_READ, 3'h0, 12'h000) ^ pat, i[0]);
      check("check error", e0 + 1, err_cnt);
      wait_replies(0);
    end
    send(mk(3'h2, CLS_READ, 3'h0, 12'h000), 1'b0);
    wait_replies(0);
    $display("test errors done");
    new_live(1'b0);
    for (int g = 0; g < NP; g++) an_frz[g] = an_live[g];
    send(mk(ADDR_ALL, CLS_SPECIAL, CODE_AD_LOCK, 12'h000), 1'b0);
    fa = 1'b1;
    check("freeze flags", 2'b10, {a_frz, c_frz});
    flush();
    new_live(1'b0);
    do_read(0, 4, 1'b1);
    for (int g = 0; g < NP; g++) pc_frz[g] = pc_live[g];
    send(mk(STN, CLS_SPECIAL, CODE_PC_LOCK, 12'h000), 1'b1);
    fc = 1'b1;
    check("freeze flags", 2'b11, {a_frz, c_frz});
    flush();
    new_live(1'b0);
    do_read(2, 3, 1'b0);
    send(mk(STN, CLS_HOUSEKEEP, CODE_RST_LOCK, 12'h000), 1'b0);
    fa = 1'b0;
    fc = 1'b0;
    check("freeze flags", 2'b00, {a_frz, c_frz});
    flush();
    new_live(1'b1);
    do_read(0, 4, 1'b0);
    $display("test lockup done");
    stop_test();
  end
endmodule

//--- rtl/msg_skid_buffer.sv
// two-entry valid/ready buffer for outgoing reply words
`timescale 1ns/1ps
module msg_skid_buffer #(
  parameter int WIDTH = 32
) (
  input  wire logic             core_clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  logic [WIDTH-1:0] slot [2];
  logic [1:0]       count;
  logic [WIDTH-1:0] next_slot0;
  logic [WIDTH-1:0] next_slot1;
  logic [1:0]       next_count;
  logic             push;
  logic             pop;

  always_comb begin
    push       = in_valid_in && (count != 2'h2);
    pop        = out_valid_out && out_ready_in;
    next_count = 2'((count + {1'b0, push}) - {1'b0, pop});
    next_slot0 = slot[0];
    next_slot1 = slot[1];
    // slot0 always holds the head word
    if (pop) begin
      next_slot0 = slot[1];
    end
    if (push) begin
      if (next_count == 2'h1) begin
        next_slot0 = in_data_in;
      end else begin
        next_slot1 = in_data_in;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count         <= 2'h0;
      slot[0]       <= '0;
      slot[1]       <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else begin
      count         <= next_count;
      slot[0]       <= next_slot0;
      slot[1]       <= next_slot1;
      in_ready_out  <= (next_count != 2'h2);
      out_valid_out <= (next_count != 2'h0);
      out_data_out  <= next_slot0;
    end
  end
endmodule

//--- rtl/remote_station_message_handler.sv
// message receiver, decoder, lockup freeze and reply formatter of the remote terminal
`timescale 1ns/1ps
// Summary of operation
// - over-range analog input reported all ones; counters reported as 12-bit binary.
// - analog lockup captures every analog point; replies return captures until reset.
// - counter lockup captures every counter; replies return captures until reset.
// - 24 information bits plus 8 check bits, all 32 checked.
// - message is 32 bits after two sync characters marking its start.
// - control needs selection, checkback reply, then activate from the master.
// - no action on bad check or a message out of sequence.
// - selection cleared if the next message is not a control execute.
// - check detects all single, double and up-to-8-bit burst errors.
// - accept scan/control messages; reply with verifications and telemetry data.
// - check bits are remainder of info times x^8 by x^8+x^7+x^6+1.
// - header: address 0-2, group 3-5, class 6-8, function code 9-11.
// - lockup acted on at own address or address 0 (ADDR_ALL); nothing else is at address 0.
// - analog value: sign bit (1 positive) then 11-bit magnitude msb first.
module remote_station_message_handler
  import rsm_pkg::*;
#(
  parameter int          POINTS      = 8,
  parameter logic [7:0]  SYNC_CHAR   = SYNC_DEFAULT,
  parameter logic [2:0]  STATION     = 3'h1
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rstn_in,
  input  wire logic                    rx_bit_in,
  input  wire logic                    rx_bit_valid_in,
  input  wire logic [POINTS*12-1:0]    analog_values_in,
  input  wire logic [POINTS-1:0]       analog_over_range_in,
  input  wire logic [POINTS*12-1:0]    counter_values_in,
  output logic                         reply_valid_out,
  input  wire logic                    reply_ready_in,
  output logic [MSG_BITS-1:0]          reply_data_out,
  output logic                         select_out,
  output logic [2:0]                   select_code_out,
  output logic                         execute_out,
  output logic                         analog_frozen_out,
  output logic                         counter_frozen_out,
  output logic                         check_error_out
);
  typedef enum logic [1:0] {HUNT, SYNC2, BODY} rx_state_t;

  // serial remainder step over one bit; feeding all 32 bits leaves the syndrome
  function automatic logic [7:0] chk_step(input logic [7:0] r, input logic b);
    logic fb;
    fb = r[7] ^ b;
    return fb ? ({r[6:0], 1'b0} ^ CHK_POLY) : {r[6:0], 1'b0};
  endfunction

  // analog points are sign/magnitude; over range replaces the word by all ones
  function automatic logic [11:0] analog_word(input logic [11:0] v, input logic ovr);
    return ovr ? OVER_RANGE : v;
  endfunction

  // remainder of the 24 info bits, sent high bit first after them, so that the
  // far receiver's remainder over all 32 bits comes out zero
  function automatic logic [MSG_BITS-1:0] seal_word(input logic [INFO_BITS-1:0] inf);
    logic [CHK_BITS-1:0] r;
    logic [MSG_BITS-1:0] w;
    r = '0;
    for (int i = 0; i < INFO_BITS; i++) begin
      r = chk_step(r, inf[i]);
    end
    w = {{CHK_BITS{1'b0}}, inf};
    for (int k = 0; k < CHK_BITS; k++) begin
      w[INFO_BITS + k] = r[CHK_BITS - 1 - k];
    end
    return w;
  endfunction

  rx_state_t            rx_state, next_rx_state;
  logic [7:0]           sync_sh, next_sync_sh;
  logic [MSG_BITS-1:0]  body, next_body;
  logic [5:0]           bit_cnt, next_bit_cnt;
  logic [7:0]           rem, next_rem;
  logic                 msg_done, next_msg_done;
  logic [7:0]           last_rem;
  logic [7:0]           next_last_rem;
  logic [11:0]          frz_a [POINTS];
  logic [11:0]          frz_c [POINTS];
  logic                 next_af, next_cf, next_sel, next_exec, next_err;
  logic [2:0]           next_sel_code;
  logic                 cap_a, cap_c;
  logic                 buf_ready;
  logic                 rq_valid, next_rq_valid;
  logic [MSG_BITS-1:0]  rq_data, next_rq_data;
  logic [2:0]           rd_ptr, next_rd_ptr;
  logic [3:0]           rd_left, next_rd_left;
  logic [INFO_BITS-1:0] enc_info;
  logic [11:0]          wa, wb;
  logic [2:0]           pa, pb;
  logic                 hdr_ok, addr_me, is_lock, chk_ok;
  logic [2:0]           m_addr, m_cls, m_code;
  // receive framing: two sync characters then 32 message bits
  always_comb begin
    next_rx_state = rx_state;
    next_sync_sh  = sync_sh;
    next_body     = body;
    next_bit_cnt  = bit_cnt;
    next_rem      = rem;
    next_msg_done = 1'b0;
    next_last_rem = last_rem;
    if (rx_bit_valid_in) begin
      unique case (rx_state)
        HUNT: begin
          next_sync_sh = {sync_sh[6:0], rx_bit_in};
          if ({sync_sh[6:0], rx_bit_in} == SYNC_CHAR) begin
            next_rx_state = SYNC2;
            next_sync_sh  = 8'h00;
            next_bit_cnt  = 6'h00;
          end
        end
        SYNC2: begin
          next_sync_sh = {sync_sh[6:0], rx_bit_in};
          next_bit_cnt = 6'(bit_cnt + 6'h01);
          if (bit_cnt == 6'h07) begin
            next_bit_cnt = 6'h00;
            next_rem     = 8'h00;
            next_rx_state = ({sync_sh[6:0], rx_bit_in} == SYNC_CHAR) ? BODY : HUNT;
          end
        end
        BODY: begin
          next_body    = {rx_bit_in, body[MSG_BITS-1:1]};  // bit 0 arrives first
          next_rem     = chk_step(rem, rx_bit_in);
          next_bit_cnt = 6'(bit_cnt + 6'h01);
          if (bit_cnt == 6'(MSG_BITS - 1)) begin
            next_msg_done = 1'b1;
            next_last_rem = chk_step(rem, rx_bit_in);
            next_rx_state = HUNT;
            next_sync_sh  = 8'h00;
          end
        end
        default: next_rx_state = HUNT;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_state <= HUNT;
      sync_sh  <= 8'h00;
      body     <= '0;
      bit_cnt  <= 6'h00;
      rem      <= 8'h00;
      msg_done <= 1'b0;
      last_rem <= 8'h00;
    end else begin
      rx_state <= next_rx_state;
      sync_sh  <= next_sync_sh;
      body     <= next_body;
      bit_cnt  <= next_bit_cnt;
      rem      <= next_rem;
      msg_done <= next_msg_done;
      last_rem <= next_last_rem;
    end
  end

  // decode of a completed message
  always_comb begin
    m_addr  = body[ADDR_LSB +: 3];
    m_cls   = body[CLASS_LSB +: 3];
    m_code  = body[CODE_LSB +: 3];
    chk_ok  = (last_rem == 8'h00);
    addr_me = (m_addr == STATION);
    is_lock = (m_cls == CLS_SPECIAL) &&
              (m_code == CODE_AD_LOCK || m_code == CODE_PC_LOCK);
    hdr_ok  = msg_done && chk_ok;
    next_err = msg_done && !chk_ok;
    next_af = analog_frozen_out;
    next_cf = counter_frozen_out;
    next_sel = select_out;
    next_sel_code = select_code_out;
    next_exec = 1'b0;
    cap_a = 1'b0;
    cap_c = 1'b0;
    next_rq_valid = 1'b0;
    next_rq_data  = rq_data;
    if (hdr_ok && is_lock && (addr_me || m_addr == ADDR_ALL)) begin
      next_sel = 1'b0;
      cap_a = (m_code == CODE_AD_LOCK) && !analog_frozen_out;
      cap_c = (m_code == CODE_PC_LOCK) && !counter_frozen_out;
      if (m_code == CODE_AD_LOCK) next_af = 1'b1;
      if (m_code == CODE_PC_LOCK) next_cf = 1'b1;
    end else if (hdr_ok && addr_me) begin
      // any accepted message other than a control select drops the selection, an execute included
      next_sel = 1'b0;
      if (m_cls == CLS_HOUSEKEEP && m_code == CODE_RST_LOCK) begin
        next_af = 1'b0;
        next_cf = 1'b0;
      end
      if (m_cls == CLS_CTRL_SEL) begin
        next_sel      = 1'b1;
        next_sel_code = m_code;
        next_rq_valid = 1'b1;
        next_rq_data  = {8'h00, body[INFO_BITS-1:0]};       // checkback echoes selection
      end else if ((m_cls == CLS_MEM_ACT || m_cls == CLS_LATCH_ACT) && select_out &&
                   m_code == select_code_out) begin
        next_exec     = 1'b1;
        next_sel      = 1'b0;
        next_rq_valid = 1'b1;
        next_rq_data  = {8'h00, body[INFO_BITS-1:0]};       // operation verification
      end
    end
  end

  // frozen images: loaded only on the lockup that sets the flag
  generate
    for (genvar g = 0; g < POINTS; g++) begin : g_frz
      always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          frz_a[g] <= 12'h000;
          frz_c[g] <= 12'h000;
        end else begin
          if (cap_a) frz_a[g] <= analog_word(analog_values_in[g*12 +: 12],
                                             analog_over_range_in[g]);
          if (cap_c) frz_c[g] <= counter_values_in[g*12 +: 12];
        end
      end
    end
  endgenerate

  // telemetry read: a pair of 12-bit words per reply, sign/magnitude for analog
  always_comb begin
    next_rd_ptr      = rd_ptr;
    next_rd_left     = rd_left;
    pa = rd_ptr;
    pb = 3'(rd_ptr + 3'h1);
    wa = analog_frozen_out ? frz_a[pa] :
         analog_word(analog_values_in[pa*12 +: 12], analog_over_range_in[pa]);
    wb = counter_frozen_out ? frz_c[pb] : counter_values_in[pb*12 +: 12];
    if (hdr_ok && addr_me && m_cls == CLS_READ && !is_lock) begin
      next_rd_left     = {1'b0, m_code} + 4'h1;
      next_rd_ptr      = body[DATA_LSB +: 3];
    end else if (rd_left != 4'h0 && !rq_valid && buf_ready) begin
      next_rd_left = 4'(rd_left - 4'h1);
      next_rd_ptr  = 3'(rd_ptr + 3'h2);
    end
    enc_info = {wb, wa};
  end

  logic                push_valid;
  logic [MSG_BITS-1:0] push_data;
  always_comb begin
    push_valid = rq_valid || (rd_left != 4'h0);
    push_data  = rq_valid ? seal_word(rq_data[INFO_BITS-1:0]) : seal_word(enc_info);
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      analog_frozen_out  <= 1'b0;
      counter_frozen_out <= 1'b0;
      select_out         <= 1'b0;
      select_code_out    <= 3'h0;
      execute_out        <= 1'b0;
      check_error_out    <= 1'b0;
      rq_valid           <= 1'b0;
      rq_data            <= '0;
      rd_ptr             <= 3'h0;
      rd_left            <= 4'h0;
    end else begin
      analog_frozen_out  <= next_af;
      counter_frozen_out <= next_cf;
      select_out         <= next_sel;
      select_code_out    <= next_sel_code;
      execute_out        <= next_exec;
      check_error_out    <= next_err;
      rq_valid           <= next_rq_valid || (rq_valid && !buf_ready);
      rq_data            <= next_rq_valid ? next_rq_data : rq_data;
      rd_ptr             <= next_rd_ptr;
      rd_left            <= next_rd_left;
    end
  end

  msg_skid_buffer #(.WIDTH(MSG_BITS)) u_buf (
    .core_clk_in   (core_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (buf_ready),
    .in_data_in    (push_data),
    .out_valid_out (reply_valid_out),
    .out_ready_in  (reply_ready_in),
    .out_data_out  (reply_data_out)
  );

  default clocking cb_core @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_bad_no_exec;
    (msg_done && !chk_ok) |=> !execute_out && $stable(select_out);
  endproperty
  a_bad_no_exec: assert property (p_bad_no_exec)
    else $error("action on failed check");
  property p_exec_needs_sel;
    $rose(execute_out) |-> $past(select_out) && !select_out;
  endproperty
  a_exec_needs_sel: assert property (p_exec_needs_sel)
    else $error("execute without selection");
  property p_sel_drop;
    (hdr_ok && select_out && m_cls != CLS_CTRL_SEL &&
     (addr_me || (is_lock && m_addr == ADDR_ALL))) |=> !select_out;
  endproperty
  a_sel_drop: assert property (p_sel_drop)
    else $error("selection kept after other message");
  property p_af_hold;
    (analog_frozen_out && !(hdr_ok && m_cls == CLS_HOUSEKEEP && m_code == CODE_RST_LOCK))
    |=> analog_frozen_out;
  endproperty
  a_af_hold: assert property (p_af_hold)
    else $error("analog freeze lost");
  property p_cf_frozen;
    (counter_frozen_out && !cap_c) |=> $stable(frz_c[0]);
  endproperty
  a_cf_frozen: assert property (p_cf_frozen)
    else $error("counter capture changed");
  property p_rst_both;
    (hdr_ok && addr_me && m_cls == CLS_HOUSEKEEP && m_code == CODE_RST_LOCK)
    |=> !analog_frozen_out && !counter_frozen_out;
  endproperty
  a_rst_both: assert property (p_rst_both)
    else $error("reset of lockup failed");
  property p_len;
    msg_done |-> $past(rx_state) == BODY;
  endproperty
  a_len: assert property (p_len)
    else $error("message end outside body");
  property p_err_flag;
    (msg_done && last_rem != 8'h00) |=> check_error_out;
  endproperty
  a_err_flag: assert property (p_err_flag)
    else $error("bad remainder not flagged");
  c_exec: cover property (@(posedge core_clk_in) execute_out);
  c_lock: cover property (@(posedge core_clk_in) $rose(analog_frozen_out));
  c_reply: cover property (@(posedge core_clk_in) reply_valid_out && !reply_ready_in);
endmodule

//--- rtl/rsm_pkg.sv
// shared constants and types for the remote station message handler
package rsm_pkg;
  localparam int MSG_BITS       = 32;
  localparam int INFO_BITS      = 24;
  localparam int CHK_BITS       = 8;
  localparam logic [7:0] CHK_POLY = 8'hC1;  // x^8+x^7+x^6+1, x^8 implied
  localparam logic [7:0] SYNC_DEFAULT = 8'h16;
  localparam int ADDR_LSB       = 0;
  localparam int GROUP_LSB      = 3;
  localparam int CLASS_LSB      = 6;
  localparam int CODE_LSB       = 9;
  localparam int DATA_LSB       = 12;
  localparam logic [2:0] ADDR_ALL      = 3'h0;
  localparam logic [2:0] CLS_CTRL_SEL  = 3'h0;
  localparam logic [2:0] CLS_MEM_ACT   = 3'h1;
  localparam logic [2:0] CLS_LATCH_ACT = 3'h2;
  localparam logic [2:0] CLS_HOUSEKEEP = 3'h3;
  localparam logic [2:0] CLS_READ      = 3'h4;
  localparam logic [2:0] CLS_SPECIAL   = 3'h7;
  localparam logic [2:0] CODE_RST_LOCK = 3'h2;
  localparam logic [2:0] CODE_AD_LOCK  = 3'h1;
  localparam logic [2:0] CODE_PC_LOCK  = 3'h2;
  localparam logic [11:0] OVER_RANGE   = 12'hFFF;
  typedef enum logic [1:0] {RPL_CHECKBACK, RPL_OPER, RPL_DATA} reply_kind_t;
endpackage
